// ===== verilog/irs_defs.svh
// Bit positions, reset values and sizes of the integer register state.
//
// Function
// - Thirty-two 64-bit general registers, chosen by a 5-bit specifier.
// - Non-vector operations read and write only the low word, bits 32-63; IRS_OP_WRITE64 writes the whole 64-bit register.
// - Sticky overflow sets with overflow except on moves; move-to-exception loads it, move-to-field clears it.
// - Exception-register move of sticky 0, overflow 1 gives exactly that.
// - Compares and ops unable to overflow keep sticky and overflow flags.
// - Enabled add, subtract-from, negate: overflow is carry32 xor carry33.
// - Enabled multiply-low, divide-word flag results exceeding 32 bits.
// - Carrying and extended add or subtract-from set carry on carry out.
// - Algebraic right shift sets carry for negative operand losing ones.
// - Compares and non-carrying ops leave the carry flag unchanged.
// - Exception bits 57-63: string byte count; 35-56 reserved, zero.
// - Condition word is eight 4-bit fields, zero to seven, bits 32-63.
// - Move-to-condition-fields loads only selected fields from register.
// - A field may be copied from another field or exception register.
// - Record-form integer ops update field zero from the result.
// - Integer and vector compares write the named field.
// - Condition bit operands address bit operand plus 32.
// - Field zero: negative, positive, zero, then sticky overflow.
// - Signed or unsigned compare: less, greater, equal, then sticky flag.
// - Vector compare: high equal, low equal, their OR, their AND.
// - Logic ops combine condition bits; any single bit can be tested.
// - Record update: low word signed against zero, then final sticky.
`ifndef IRS_DEFS_SVH
`define IRS_DEFS_SVH

`define IRS_GPR_COUNT 32
`define IRS_GPR_ADDR_W 5
`define IRS_GPR_W 64
`define IRS_WORD_W 32
`define IRS_CR_FIELDS 8
`define IRS_CR_FIELD_W 4
`define IRS_BIT_BASE 32
`define IRS_XER_SO_POS 31
`define IRS_XER_OV_POS 30
`define IRS_XER_CA_POS 29
`define IRS_XER_CNT_MSB 6
`define IRS_XER_CNT_LSB 0
`define IRS_XER_WRITE_MASK 32'hE000007F
`define IRS_XER_RESET 32'h00000000
`define IRS_CR_RESET 32'h00000000
`define IRS_GPR_RESET 64'h0000000000000000

`endif

// ===== verilog/irs_pkg.sv
// Operation and condition-logic types of the integer register state.
package irs_pkg;

    typedef enum logic [4:0] {
        IRS_OP_NOP,
        IRS_OP_ADD,
        IRS_OP_ADDC,
        IRS_OP_ADDE,
        IRS_OP_SUBF,
        IRS_OP_SUBFC,
        IRS_OP_SUBFE,
        IRS_OP_NEG,
        IRS_OP_MULLW,
        IRS_OP_DIVW,
        IRS_OP_DIVWU,
        IRS_OP_SRAW,
        IRS_OP_AND,
        IRS_OP_CMP,
        IRS_OP_MTXER,
        IRS_OP_MCRXR,
        IRS_OP_MTCRF,
        IRS_OP_MCRF,
        IRS_OP_CRLOGIC,
        IRS_OP_CRTEST,
        IRS_OP_VCMP,
        IRS_OP_CRSET,
        IRS_OP_WRITE64
    } irs_op_t;

    typedef enum logic [2:0] {
        IRS_CL_AND,
        IRS_CL_OR,
        IRS_CL_XOR,
        IRS_CL_NAND,
        IRS_CL_NOR,
        IRS_CL_EQV,
        IRS_CL_ANDC,
        IRS_CL_ORC
    } irs_crlogic_t;

endpackage : irs_pkg

// ===== verilog/irs_alu_if.sv
// Operand and flag carrier between the register state and its word ALU.
interface irs_alu_if;
    import irs_pkg::*;
    irs_op_t op;
    logic [31:0] a;
    logic [31:0] b;
    logic caIn;
    logic oe;
    logic signedCmp;
    logic [31:0] result;
    logic ovWrite;
    logic ovOut;
    logic caWrite;
    logic caOut;
    logic lt;
    logic gt;
    logic eq;

    modport alu (
        input op, a, b, caIn, oe, signedCmp,
        output result, ovWrite, ovOut, caWrite, caOut, lt, gt, eq
    );
    modport core (
        output op, a, b, caIn, oe, signedCmp,
        input result, ovWrite, ovOut, caWrite, caOut, lt, gt, eq
    );
endinterface : irs_alu_if

// ===== verilog/irs_int_alu.sv
// Word arithmetic with overflow, carry and compare outcomes.
module irs_int_alu
    import irs_pkg::*;
(
    irs_alu_if.alu bus
);
    always_comb begin
        logic [31:0] x;
        logic [31:0] y;
        logic cin;
        logic [32:0] sum;
        logic [31:0] low;
        logic signed [63:0] prod;
        logic [31:0] lostMask;
        x = bus.a;
        y = bus.b;
        cin = 1'b0;
        case (bus.op)
            IRS_OP_ADDE: cin = bus.caIn;
            IRS_OP_SUBF, IRS_OP_SUBFC: begin
                x = ~bus.a;
                cin = 1'b1;
            end
            IRS_OP_SUBFE: begin
                x = ~bus.a;
                cin = bus.caIn;
            end
            IRS_OP_NEG: begin
                x = ~bus.a;
                y = 32'h00000000;
                cin = 1'b1;
            end
            default: cin = 1'b0;
        endcase
        sum = {1'b0, x} + {1'b0, y} + {32'h00000000, cin};
        low = {1'b0, x[30:0]} + {1'b0, y[30:0]} + {31'h00000000, cin};
        prod = $signed(bus.a) * $signed(bus.b);
        lostMask = ~(32'hFFFFFFFF << bus.b[4:0]);
        bus.result = sum[31:0];
        bus.ovOut = sum[32] ^ low[31];
        bus.caOut = sum[32];
        bus.ovWrite = 1'b0;
        bus.caWrite = 1'b0;
        case (bus.op)
            IRS_OP_ADD, IRS_OP_SUBF, IRS_OP_NEG: begin
                bus.ovWrite = bus.oe;
            end
            IRS_OP_ADDC, IRS_OP_ADDE, IRS_OP_SUBFC, IRS_OP_SUBFE: begin
                bus.ovWrite = bus.oe;
                bus.caWrite = 1'b1;
            end
            IRS_OP_MULLW: begin
                bus.result = prod[31:0];
                bus.ovOut = (prod[63:31] != {33{prod[31]}});
                bus.ovWrite = bus.oe;
            end
            IRS_OP_DIVW: begin
                bus.ovOut = (bus.b == 32'h00000000) ||
                    (bus.a == 32'h80000000 && bus.b == 32'hFFFFFFFF);
                bus.result = bus.ovOut ? 32'h00000000 :
                    32'($signed(bus.a) / $signed(bus.b));
                bus.ovWrite = bus.oe;
            end
            IRS_OP_DIVWU: begin
                bus.ovOut = (bus.b == 32'h00000000);
                bus.result = bus.ovOut ? 32'h00000000 : bus.a / bus.b;
                bus.ovWrite = bus.oe;
            end
            IRS_OP_SRAW: begin
                if (bus.b[5]) begin
                    bus.result = {32{bus.a[31]}};
                    bus.caOut = bus.a[31] && (bus.a != 32'h00000000);
                end else begin
                    bus.result = 32'($signed(bus.a) >>> bus.b[4:0]);
                    bus.caOut = bus.a[31] && |(bus.a & lostMask);
                end
                bus.caWrite = 1'b1;
            end
            IRS_OP_AND: bus.result = bus.a & bus.b;
            default: bus.result = sum[31:0];
        endcase
        if (bus.signedCmp) begin
            bus.lt = $signed(bus.a) < $signed(bus.b);
            bus.gt = $signed(bus.a) > $signed(bus.b);
        end else begin
            bus.lt = bus.a < bus.b;
            bus.gt = bus.a > bus.b;
        end
        bus.eq = (bus.a == bus.b);
    end
endmodule : irs_int_alu

// ===== verilog/irs_register_state.sv
// Integer register file with exception and condition registers.
`include "irs_defs.svh"

module irs_register_state
    import irs_pkg::*;
#(
    parameter int GPR_COUNT = `IRS_GPR_COUNT,
    parameter int ADDR_W = `IRS_GPR_ADDR_W
)(
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic opValid,
    input wire irs_op_t opCode,
    input wire logic [ADDR_W-1:0] opDest,
    input wire logic [ADDR_W-1:0] opSrcA,
    input wire logic [ADDR_W-1:0] opSrcB,
    input wire logic opUseImm,
    input wire logic [31:0] opImm,
    input wire logic opOe,
    input wire logic opRc,
    input wire logic opSigned,
    input wire logic [2:0] opField,
    input wire logic [2:0] opSrcField,
    input wire logic [7:0] opFieldMask,
    input wire logic [4:0] opBitA,
    input wire logic [4:0] opBitB,
    input wire logic [4:0] opBitD,
    input wire irs_crlogic_t opLogic,
    input wire logic [3:0] opOutcome,
    input wire logic [63:0] opData64,
    input wire logic [ADDR_W-1:0] rdAddrA,
    input wire logic [ADDR_W-1:0] rdAddrB,
    output logic [63:0] rdDataA_q,
    output logic [63:0] rdDataB_q,
    output logic [31:0] xer_q,
    output logic [31:0] cr_q,
    output logic bitTest_q
);
    // =========================================================================
    // Elaboration checks
    if (GPR_COUNT != (1 << ADDR_W) || GPR_COUNT != `IRS_GPR_COUNT) begin : gChk
        $error("Register count must be 32 with a 5-bit specifier.");
    end

    // =========================================================================
    // Helpers
    // Condition bit operand p sits at architected bit 32 + p, stored MSB-first.
    function automatic logic [4:0] bitIdx(input logic [4:0] p);
        bitIdx = 5'(`IRS_BIT_BASE - 1 - int'(p));
    endfunction : bitIdx

    function automatic logic [3:0] fieldGet(input logic [31:0] c,
                                            input logic [2:0] f);
        fieldGet = c[31 - 4 * f -: `IRS_CR_FIELD_W];
    endfunction : fieldGet

    function automatic logic [31:0] fieldSet(input logic [31:0] c,
                                             input logic [2:0] f,
                                             input logic [3:0] v);
        logic [31:0] r;
        r = c;
        r[31 - 4 * f -: `IRS_CR_FIELD_W] = v;
        fieldSet = r;
    endfunction : fieldSet

    // =========================================================================
    // Storage and operand fetch
    logic [63:0] gprMem [GPR_COUNT];
    logic [31:0] xerWord;
    logic [31:0] crWord;
    logic [63:0] srcA;
    logic [63:0] srcB;
    logic go;
    logic writesGpr;

    assign go = clkEn && opValid;
    assign srcA = gprMem[opSrcA];
    assign srcB = gprMem[opSrcB];
    assign xer_q = xerWord;
    assign cr_q = crWord;

    irs_alu_if aluBus ();

    assign aluBus.op = opCode;
    assign aluBus.a = srcA[31:0];
    assign aluBus.b = opUseImm ? opImm : srcB[31:0];
    assign aluBus.caIn = xerWord[`IRS_XER_CA_POS];
    assign aluBus.oe = opOe;
    assign aluBus.signedCmp = opSigned;

    irs_int_alu uAlu (
        .bus(aluBus)
    );

    always_comb begin
        case (opCode)
            IRS_OP_ADD, IRS_OP_ADDC, IRS_OP_ADDE, IRS_OP_SUBF, IRS_OP_SUBFC,
            IRS_OP_SUBFE, IRS_OP_NEG, IRS_OP_MULLW, IRS_OP_DIVW,
            IRS_OP_DIVWU, IRS_OP_SRAW, IRS_OP_AND: writesGpr = 1'b1;
            default: writesGpr = 1'b0;
        endcase
    end

    // =========================================================================
    // Exception register next value
    logic [31:0] xerNext;

    always_comb begin
        xerNext = xerWord;
        if (go) begin
            case (opCode)
                IRS_OP_MTXER: begin
                    xerNext = srcA[31:0] & `IRS_XER_WRITE_MASK;
                end
                IRS_OP_MCRXR: begin
                    xerNext[`IRS_XER_SO_POS] = 1'b0;
                    xerNext[`IRS_XER_OV_POS] = 1'b0;
                    xerNext[`IRS_XER_CA_POS] = 1'b0;
                end
                default: begin
                    if (aluBus.ovWrite) begin
                        xerNext[`IRS_XER_OV_POS] = aluBus.ovOut;
                        if (aluBus.ovOut) begin
                            xerNext[`IRS_XER_SO_POS] = 1'b1;
                        end
                    end
                    if (aluBus.caWrite) begin
                        xerNext[`IRS_XER_CA_POS] = aluBus.caOut;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            xerWord <= `IRS_XER_RESET;
        end else if (clkEn) begin
            xerWord <= xerNext;
        end
    end

    // =========================================================================
    // General-purpose register writes
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < GPR_COUNT; i++) begin
                gprMem[i] <= `IRS_GPR_RESET;
            end
        end else if (go) begin
            if (opCode == IRS_OP_WRITE64) begin
                gprMem[opDest] <= opData64;
            end else if (writesGpr) begin
                gprMem[opDest][31:0] <= aluBus.result;
            end
        end
    end

    // =========================================================================
    // Condition register
    logic [3:0] recField;
    logic [3:0] cmpField;
    logic [3:0] vecField;
    logic hiEq;
    logic loEq;
    logic bitA;
    logic bitB;
    logic bitD;

    always_comb begin
        if (aluBus.result[31]) begin
            recField = 4'h8;
        end else if (aluBus.result != 32'h00000000) begin
            recField = 4'h4;
        end else begin
            recField = 4'h2;
        end
        recField[0] = xerNext[`IRS_XER_SO_POS];
    end

    assign cmpField = {aluBus.lt, aluBus.gt, aluBus.eq,
                       xerWord[`IRS_XER_SO_POS]};
    assign hiEq = (srcA[63:32] == srcB[63:32]);
    assign loEq = (srcA[31:0] == srcB[31:0]);
    assign vecField = {hiEq, loEq, hiEq | loEq, hiEq & loEq};
    assign bitA = crWord[bitIdx(opBitA)];
    assign bitB = crWord[bitIdx(opBitB)];

    always_comb begin
        case (opLogic)
            IRS_CL_AND: bitD = bitA & bitB;
            IRS_CL_OR: bitD = bitA | bitB;
            IRS_CL_XOR: bitD = bitA ^ bitB;
            IRS_CL_NAND: bitD = ~(bitA & bitB);
            IRS_CL_NOR: bitD = ~(bitA | bitB);
            IRS_CL_EQV: bitD = ~(bitA ^ bitB);
            IRS_CL_ANDC: bitD = bitA & ~bitB;
            IRS_CL_ORC: bitD = bitA | ~bitB;
            default: bitD = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            crWord <= `IRS_CR_RESET;
        end else if (go) begin
            case (opCode)
                IRS_OP_CMP: crWord <= fieldSet(crWord, opField, cmpField);
                IRS_OP_VCMP: crWord <= fieldSet(crWord, opField, vecField);
                IRS_OP_CRSET: crWord <= fieldSet(crWord, opField, opOutcome);
                IRS_OP_MCRF: begin
                    crWord <= fieldSet(crWord, opField,
                                       fieldGet(crWord, opSrcField));
                end
                IRS_OP_MCRXR: begin
                    crWord <= fieldSet(crWord, opField, xerWord[31:28]);
                end
                IRS_OP_MTCRF: begin
                    for (int f = 0; f < `IRS_CR_FIELDS; f++) begin
                        if (opFieldMask[f]) begin
                            crWord[31 - 4 * f -: 4] <= srcA[31 - 4 * f -: 4];
                        end
                    end
                end
                IRS_OP_CRLOGIC: crWord[bitIdx(opBitD)] <= bitD;
                default: begin
                    if (writesGpr && opRc) begin
                        crWord <= fieldSet(crWord, 3'h0, recField);
                    end
                end
            endcase
        end
    end

    // =========================================================================
    // Read ports and bit test
    always_ff @(posedge clk) begin
        if (reset) begin
            rdDataA_q <= `IRS_GPR_RESET;
            rdDataB_q <= `IRS_GPR_RESET;
        end else if (clkEn) begin
            rdDataA_q <= gprMem[rdAddrA];
            rdDataB_q <= gprMem[rdAddrB];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            bitTest_q <= 1'b0;
        end else if (go && opCode == IRS_OP_CRTEST) begin
            bitTest_q <= bitA;
        end
    end

endmodule : irs_register_state

// ===== verif/irs_register_state_monitor.sv
// Concurrent checks on the integer register state ports.
module irs_register_state_monitor
    import irs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic opValid,
    input wire irs_op_t opCode,
    input wire logic opRc,
    input wire logic [2:0] opField,
    input wire logic [7:0] opFieldMask,
    input wire logic [3:0] opOutcome,
    input wire logic [31:0] xer_q,
    input wire logic [31:0] cr_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tk;
    assign tk = clkEn & opValid;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    function automatic logic [3:0] fld(logic [31:0] c, logic [2:0] f);
        return c[31 - 4 * f -: 4];
    endfunction : fld

    property p_reset_clear;
        disable iff (1'b0) reset |=> xer_q == 32'h0 && cr_q == 32'h0;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("flags not cleared by reset");
    property p_reserved;
        xer_q[28:7] == 22'h0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved flag bits not zero");
    property p_sticky;
        xer_q[31] && !(tk && opCode inside {IRS_OP_MTXER, IRS_OP_MCRXR})
            |=> xer_q[31];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("sticky flag dropped");
    property p_keep;
        tk && opCode inside {IRS_OP_CMP, IRS_OP_AND} |=> $stable(xer_q);
    endproperty
    a_keep: assert property (p_keep)
        else $error("compare or logic op changed flags");
    property p_copy_flags;
        tk && opCode == IRS_OP_MCRXR |=> xer_q[31:29] == 3'h0 &&
            fld(cr_q, $past(opField)) == $past(xer_q[31:28]);
    endproperty
    a_copy_flags: assert property (p_copy_flags)
        else $error("flag copy into field wrong");
    property p_outcome;
        tk && opCode == IRS_OP_CRSET |=>
            fld(cr_q, $past(opField)) == $past(opOutcome);
    endproperty
    a_outcome: assert property (p_outcome)
        else $error("outcome not in named field");
    property p_no_fields;
        tk && opCode == IRS_OP_MTCRF && opFieldMask == 8'h00
            |=> $stable(cr_q);
    endproperty
    a_no_fields: assert property (p_no_fields)
        else $error("unselected field changed");
    property p_record;
        tk && opRc && opCode == IRS_OP_ADD |=> cr_q[28] == xer_q[31];
    endproperty
    a_record: assert property (p_record)
        else $error("field zero sticky copy wrong");
endmodule : irs_register_state_monitor

// ===== verif/irs_pipe_model.sv
// Issuing pipeline model that stalls the core by dropping the enable.
module irs_pipe_model (
    input wire logic clk,
    input wire logic stall,
    output logic clkEn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt_q = 2'h0;
    initial clkEn = 1'b1;
    // The enable changes by non-blocking assignment on the rising edge.
    always @(posedge clk) begin
        cnt_q <= cnt_q + 2'h1;
        clkEn <= !stall || cnt_q == 2'h3;
    end
endmodule : irs_pipe_model

// ===== verif/irs_register_state_bench.sv
// Self-checking bench of the integer register state.
`include "irs_defs.svh"
module irs_register_state_bench import irs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, reset = 1'b1, opValid = 1'b0, stall = 1'b0;
    logic opUseImm = 1'b0, opOe = 1'b0, opRc = 1'b0, opSigned = 1'b0;
    logic clkEn, bitTest_q, eBit;
    irs_op_t opCode = IRS_OP_NOP;
    irs_crlogic_t opLogic = IRS_CL_AND;
    logic [4:0] opDest = 5'h0, opSrcA = 5'h0, opSrcB = 5'h0;
    logic [4:0] opBitA = 5'h0, opBitB = 5'h0, opBitD = 5'h0;
    logic [4:0] rdAddrA = 5'h0, rdAddrB = 5'h0;
    logic [2:0] opField = 3'h0, opSrcField = 3'h0, lsel = 3'h0;
    logic [7:0] opFieldMask = 8'h0;
    logic [3:0] opOutcome = 4'h0;
    logic [31:0] opImm = 32'h0, xer_q, cr_q, eFlags, eCond;
    logic [63:0] opData64 = 64'h0, rdDataA_q, rdDataB_q;
    logic [63:0] regs [32];
    int fails = 0, num_checks = 0;
    irs_op_t ops [$] = '{IRS_OP_ADD, IRS_OP_ADDC, IRS_OP_ADDE, IRS_OP_SUBF,
        IRS_OP_SUBFC, IRS_OP_NEG, IRS_OP_MULLW, IRS_OP_SRAW, IRS_OP_AND,
        IRS_OP_SUBFE, IRS_OP_DIVW, IRS_OP_DIVWU,
        IRS_OP_CMP, IRS_OP_MTXER, IRS_OP_MCRXR, IRS_OP_MTCRF, IRS_OP_MCRF,
        IRS_OP_CRLOGIC, IRS_OP_CRTEST, IRS_OP_VCMP, IRS_OP_CRSET,
        IRS_OP_WRITE64};
    always #20 clk = ~clk;
    irs_pipe_model irs_pipe_model_inst (.clk(clk), .stall(stall),
        .clkEn(clkEn));
    irs_register_state irs_register_state_inst (.clk(clk), .reset(reset),
        .clkEn(clkEn), .opValid(opValid), .opCode(opCode), .opDest(opDest),
        .opSrcA(opSrcA), .opSrcB(opSrcB), .opUseImm(opUseImm),
        .opImm(opImm), .opOe(opOe), .opRc(opRc), .opSigned(opSigned),
        .opField(opField), .opSrcField(opSrcField),
        .opFieldMask(opFieldMask), .opBitA(opBitA), .opBitB(opBitB),
        .opBitD(opBitD), .opLogic(opLogic), .opOutcome(opOutcome),
        .opData64(opData64), .rdAddrA(rdAddrA), .rdAddrB(rdAddrB),
        .rdDataA_q(rdDataA_q), .rdDataB_q(rdDataB_q), .xer_q(xer_q),
        .cr_q(cr_q), .bitTest_q(bitTest_q));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize();
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    task automatic clear();
        foreach (regs[i]) regs[i] = 64'h0;
        eFlags = 32'h0;
        eCond = 32'h0;
        eBit = 1'b0;
    endtask : clear
    task automatic edgeEn();
        do @(posedge clk); while (clkEn !== 1'b1);
    endtask : edgeEn
    function automatic logic [3:0] getF(logic [31:0] v, logic [2:0] n);
        return v[31 - 4 * n -: 4];
    endfunction : getF
    task automatic setF(input logic [2:0] n, input logic [3:0] v);
        eCond[31 - 4 * n -: 4] = v;
    endtask : setF
    function automatic logic lgc(logic x, logic y);
        case (opLogic)
            IRS_CL_AND: return x & y;
            IRS_CL_OR: return x | y;
            IRS_CL_XOR: return x ^ y;
            IRS_CL_NAND: return !(x & y);
            IRS_CL_NOR: return !(x | y);
            IRS_CL_EQV: return x ~^ y;
            IRS_CL_ANDC: return x & !y;
            default: return x | !y;
        endcase
    endfunction : lgc
    // Result is {signed wrap, carry out, word}.
    function automatic logic [33:0] addx(logic [31:0] x, y, logic ci);
        logic [32:0] t = {1'b0, x} + {1'b0, y} + 33'(ci);
        logic c31 = x[31] ^ y[31] ^ t[31];
        return {t[32] ^ c31, t};
    endfunction : addx
    function automatic logic [33:0] mulx(logic [31:0] x, y);
        longint p = longint'($signed(x)) * longint'($signed(y));
        return {p != longint'($signed(p[31:0])), 1'b0, p[31:0]};
    endfunction : mulx
    function automatic logic [33:0] srax(logic [31:0] x, logic [5:0] n);
        logic [95:0] t = $signed({x, 64'h0}) >>> n;
        return {1'b0, x[31] && (|t[63:0]), t[95:64]};
    endfunction : srax
    function automatic logic [33:0] divx(logic [31:0] x, y, logic sg);
        logic v = y == 0 || (sg && x == 32'h80000000 && y == '1);
        return {v, 1'b0, v ? 32'h0 : sg ? 32'($signed(x) / $signed(y))
            : x / y};
    endfunction : divx
    task automatic model(input irs_op_t c);
        logic [31:0] a, b;
        logic [33:0] s;
        logic w, hi, lo;
        a = regs[opSrcA][31:0];
        b = opUseImm ? opImm : regs[opSrcB][31:0];
        w = 1'b1;
        case (c)
            IRS_OP_ADD, IRS_OP_ADDC: s = addx(a, b, 1'b0);
            IRS_OP_ADDE: s = addx(a, b, eFlags[29]);
            IRS_OP_SUBF, IRS_OP_SUBFC: s = addx(~a, b, 1'b1);
            IRS_OP_SUBFE: s = addx(~a, b, eFlags[29]);
            IRS_OP_DIVW, IRS_OP_DIVWU: s = divx(a, b, c == IRS_OP_DIVW);
            IRS_OP_NEG: s = addx(~a, 32'h0, 1'b1);
            IRS_OP_MULLW: s = mulx(a, b);
            IRS_OP_SRAW: s = srax(a, b[5:0]);
            IRS_OP_AND: s = {2'h0, a & b};
            default: w = 1'b0;
        endcase
        if (w) begin
            regs[opDest][31:0] = s[31:0];
            if (opOe && !(c inside {IRS_OP_SRAW, IRS_OP_AND})) begin
                eFlags[31:30] = {eFlags[31] | s[33], s[33]};
            end
            if (c inside {IRS_OP_ADDC, IRS_OP_ADDE, IRS_OP_SUBFC,
                IRS_OP_SUBFE, IRS_OP_SRAW}) eFlags[29] = s[32];
            if (opRc) setF(3'h0, {s[31], !s[31] && s[31:0] != 32'h0,
                s[31:0] == 32'h0, eFlags[31]});
        end
        hi = regs[opSrcA][63:32] == regs[opSrcB][63:32];
        lo = regs[opSrcA][31:0] == regs[opSrcB][31:0];
        case (c)
            IRS_OP_CMP: setF(opField, opSigned ? {$signed(a) < $signed(b),
                $signed(a) > $signed(b), a == b, eFlags[31]}
                : {a < b, a > b, a == b, eFlags[31]});
            IRS_OP_MTXER: eFlags = a & `IRS_XER_WRITE_MASK;
            IRS_OP_MCRXR: begin
                setF(opField, eFlags[31:28]);
                eFlags[31:29] = 3'h0;
            end
            IRS_OP_MTCRF: for (int i = 0; i < 8; i++)
                if (opFieldMask[i]) setF(3'(i), getF(a, 3'(i)));
            IRS_OP_MCRF: setF(opField, getF(eCond, opSrcField));
            IRS_OP_CRLOGIC: eCond[31 - opBitD] =
                lgc(eCond[31 - opBitA], eCond[31 - opBitB]);
            IRS_OP_CRTEST: eBit = eCond[31 - opBitA];
            IRS_OP_VCMP: setF(opField, {hi, lo, hi | lo, hi & lo});
            IRS_OP_CRSET: setF(opField, opOutcome);
            IRS_OP_WRITE64: regs[opDest] = opData64;
            default: ;
        endcase
    endtask : model
    task automatic go(input irs_op_t c);
        opCode <= c;
        opValid <= 1'b1;
        edgeEn();
        opValid <= 1'b0;
        rdAddrA <= opDest;
        rdAddrB <= opSrcA;
        #1;
        model(c);
        chk(xer_q, eFlags);
        chk(cr_q, eCond);
        edgeEn();
        #1;
        chk(rdDataA_q, regs[opDest]);
        chk(rdDataB_q, regs[opSrcA]);
        if (c == IRS_OP_CRTEST) chk(bitTest_q, eBit);
    endtask : go
    task automatic rnd(input irs_op_t c);
        logic [31:0] k, m;
        @(posedge clk);
        k = $urandom;
        m = $urandom;
        opDest <= k[4:0];
        opSrcA <= k[9:5];
        opSrcB <= k[14:10];
        opBitA <= k[19:15];
        opBitB <= c == IRS_OP_CRTEST ? k[19:15] : k[24:20];
        opBitD <= c == IRS_OP_CRTEST ? k[19:15] : k[29:25];
        {opUseImm, opOe, opSigned} <= m[2:0];
        opRc <= m[3] && c != IRS_OP_WRITE64;
        opField <= m[6:4];
        opSrcField <= m[9:7];
        opFieldMask <= m[17:10];
        opOutcome <= m[21:18];
        opLogic <= irs_crlogic_t'(lsel);
        lsel <= lsel + 3'h1;
        opImm <= $urandom;
        opData64 <= {$urandom, $urandom};
        go(c);
    endtask : rnd
    task automatic load(input logic [4:0] n, input logic [63:0] v);
        @(posedge clk);
        opDest <= n;
        opData64 <= v;
        opRc <= 1'b0;
        go(IRS_OP_WRITE64);
    endtask : load
    task automatic cor(input irs_op_t c, input logic [4:0] d, a, b);
        @(posedge clk);
        opDest <= d;
        opSrcA <= a;
        opSrcB <= b;
        opOe <= 1'b1;
        opRc <= 1'b1;
        opUseImm <= 1'b0;
        opFieldMask <= 8'h00;
        go(c);
    endtask : cor
    initial begin
        #1600000;
        fails++;
        summarize();
    end
    initial begin
        void'($urandom(37963));
        clear();
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        load(5'h01, 64'h0000000040000000);
        cor(IRS_OP_MTXER, 5'h09, 5'h01, 5'h00);
        load(5'h01, 64'hFFFFFFFFFFFFFFFF);
        cor(IRS_OP_MTXER, 5'h09, 5'h01, 5'h00);
        cor(IRS_OP_MTCRF, 5'h09, 5'h01, 5'h00);
        load(5'h02, 64'h123456787FFFFFFF);
        load(5'h03, 64'h0000000000000001);
        cor(IRS_OP_ADD, 5'h02, 5'h02, 5'h03);
        cor(IRS_OP_CMP, 5'h02, 5'h02, 5'h03);
        cor(IRS_OP_SRAW, 5'h04, 5'h01, 5'h03);
        cor(IRS_OP_DIVW, 5'h05, 5'h02, 5'h00);
        cor(IRS_OP_MCRXR, 5'h04, 5'h01, 5'h03);
        repeat (8) rnd(IRS_OP_CRLOGIC);
        for (int i = 0; i < 400; i++) begin
            if (i % 100 == 50) begin
                @(posedge clk);
                stall <= !stall;
            end
            rnd(ops[$urandom_range(ops.size() - 1)]);
        end
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        #1;
        clear();
        chk(xer_q, eFlags);
        chk(cr_q, eCond);
        repeat (20) rnd(ops[$urandom_range(ops.size() - 1)]);
        summarize();
    end
endmodule : irs_register_state_bench
bind irs_register_state irs_register_state_monitor
    irs_register_state_monitor_inst (.clk(clk), .reset(reset),
    .clkEn(clkEn), .opValid(opValid), .opCode(opCode), .opRc(opRc),
    .opField(opField), .opFieldMask(opFieldMask), .opOutcome(opOutcome),
    .xer_q(xer_q), .cr_q(cr_q));
